/* swt_pkg.sv */
package swt_pkg;

  // ****************************************************************
  // Time base
  // ****************************************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_HZ = 10_240;
  localparam int MS_PER_S = 1000;
  // Nominal oscillator period in system clocks, rounded down
  localparam int OSC_DIV_CYC = CLK_HZ / OSC_HZ;
  localparam int DIV_W = 14;

  // ****************************************************************
  // Interval lengths
  // ****************************************************************
  localparam int CNT_W = 15;
  localparam int T_RST_NOM_MS = 200;
  localparam int T_SHORT_INT_MS = 100;
  localparam int T_LONG_INT_MS = 1600;
  localparam logic [CNT_W-1:0] TK_RST_INT =
    CNT_W'(T_RST_NOM_MS * OSC_HZ / MS_PER_S);
  localparam logic [CNT_W-1:0] TK_SHORT_INT =
    CNT_W'(T_SHORT_INT_MS * OSC_HZ / MS_PER_S);
  localparam logic [CNT_W-1:0] TK_LONG_INT =
    CNT_W'(T_LONG_INT_MS * OSC_HZ / MS_PER_S);
  localparam logic [CNT_W-1:0] TK_SHORT_EXT = 15'h0400;
  localparam logic [CNT_W-1:0] TK_LONG_EXT = 15'h1000;
  localparam logic [CNT_W-1:0] TK_RST_EXT = 15'h0800;

  // ****************************************************************
  // Reset values and states
  // ****************************************************************
  localparam logic [CNT_W-1:0] CNT_RST = 15'h0000;
  localparam logic [DIV_W-1:0] DIV_RST = 14'h0000;

  typedef enum logic [3:0] {
    ST_HOLD = 4'b0001,
    ST_RST = 4'b0010,
    ST_LONG = 4'b0100,
    ST_SHORT = 4'b1000
  } swt_state_t;

endpackage

/* swt_edge_if.sv */
`timescale 1ns/1ns
interface swt_edge_if;
  logic raw;
  logic level;
  logic toggle;
  logic rise;
  modport det (
    input raw,
    output level,
    output toggle,
    output rise
  );
  modport cons (
    output raw,
    input level,
    input toggle,
    input rise
  );
endinterface

/* swt_edge.sv */
`timescale 1ns/1ns
module swt_edge (
  input wire logic i_clk,
  input wire logic i_rst,
  swt_edge_if.det port
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic s1_next;
  logic s2_next;
  logic s3_next;

  always_comb begin
    s1_next = port.raw;
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  // Edges only from the second stage onward
  assign port.level = s2_reg;
  assign port.toggle = s2_reg ^ s3_reg;
  assign port.rise = s2_reg & ~s3_reg;
endmodule // swt_edge

/* swt_watchdog.sv */
// Function
// - Missed kick drives reset low, interval
// - Long timeout applies right after reset
// - Short timeout only after first kick
// - Basic variant: one fixed long timeout
// - Timeout restarts when reset goes inactive
// - Either kick edge clears the counter
// - Stuck kick repeats reset every long period
// - Floating kick input disables the watchdog
// - Power low disables the watchdog timer
// - Extended variant: expired output low until next kick
// - Power low forces expired output high
// - External clock: 1024/4096/2048 clocks
// - Internal oscillator: fixed 200ms reset
// - Timebase input picks 100ms or 1.6s
// - Internal periods counted at 10.24kHz
`timescale 1ns/1ns
module swt_watchdog
  import swt_pkg::*;
#(
  parameter bit p_extended = 1'b1,
  parameter int unsigned p_osc_div = OSC_DIV_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_kick_input,
  input wire logic i_kick_float,
  input wire logic i_timebase_select,
  input wire logic i_select_float,
  input wire logic i_timebase_input,
  input wire logic i_timebase_float,
  input wire logic i_power_low,
  output logic o_reset_n,
  output logic o_expired_output_n
);

  // ****************************************************************
  // Input edge detection
  // ****************************************************************
  swt_edge_if kick_if ();
  swt_edge_if tb_if ();

  assign kick_if.raw = i_kick_input;
  assign tb_if.raw = i_timebase_input;

  swt_edge u_kick_edge (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .port(kick_if.det)
  );

  // External clock passes the same three stages as the kick
  swt_edge u_tb_edge (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .port(tb_if.det)
  );

  // ****************************************************************
  // Time base
  // ****************************************************************
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(p_osc_div - 1);

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic ext_mode;
  logic tb_high;
  logic tick;

  always_comb begin
    if (div_reg == DIV_LAST) begin
      div_next = DIV_RST;
    end else begin
      div_next = div_reg + 14'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_reg <= DIV_RST;
    end else begin
      div_reg <= div_next;
    end
  end

  // Floating select or timebase pins read as high
  assign ext_mode = p_extended & ~(i_timebase_select | i_select_float);
  assign tb_high = tb_if.level | i_timebase_float;
  assign tick = ext_mode ? tb_if.rise : (div_reg == DIV_LAST);

  // ****************************************************************
  // Interval selection
  // ****************************************************************
  logic [CNT_W-1:0] lim_rst;
  logic [CNT_W-1:0] lim_long;
  logic [CNT_W-1:0] lim_short;

  always_comb begin
    if (!p_extended) begin
      lim_rst = TK_RST_INT;
      lim_long = TK_LONG_INT;
      lim_short = TK_LONG_INT;
    end else if (ext_mode) begin
      lim_rst = TK_RST_EXT;
      lim_long = TK_LONG_EXT;
      lim_short = TK_SHORT_EXT;
    end else begin
      lim_rst = TK_RST_INT;
      lim_long = TK_LONG_INT;
      lim_short = tb_high ? TK_LONG_INT : TK_SHORT_INT;
    end
  end

  // ****************************************************************
  // Watchdog sequencer
  // ****************************************************************
  swt_state_t state_reg;
  swt_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic rst_n_reg;
  logic rst_n_next;
  logic exp_n_reg;
  logic exp_n_next;
  logic [CNT_W-1:0] lim_wd;

  assign lim_wd = (state_reg == ST_LONG) ? lim_long : lim_short;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rst_n_next = rst_n_reg;
    exp_n_next = exp_n_reg;
    if (i_power_low) begin
      state_next = ST_HOLD;
      cnt_next = CNT_RST;
      rst_n_next = 1'b0;
      exp_n_next = 1'b1;
    end else begin
      // Any kick edge on a driven (not floating) kick input releases the expired flag, even during reset
      if (kick_if.toggle && !i_kick_float) begin
        exp_n_next = 1'b1;
      end
      case (state_reg)
        ST_HOLD: begin
          state_next = ST_RST;
          cnt_next = CNT_RST;
          rst_n_next = 1'b0;
        end
        ST_RST: begin
          rst_n_next = 1'b0;
          if (tick) begin
            if (cnt_reg == lim_rst - 15'h0001) begin
              state_next = ST_LONG;
              cnt_next = CNT_RST;
              rst_n_next = 1'b1;
            end else begin
              cnt_next = cnt_reg + 15'h0001;
            end
          end
        end
        ST_LONG, ST_SHORT: begin
          if (i_kick_float) begin
            cnt_next = CNT_RST;
          end else if (kick_if.toggle) begin
            cnt_next = CNT_RST;
            state_next = ST_SHORT;
          end else if (tick) begin
            if (cnt_reg == lim_wd - 15'h0001) begin
              state_next = ST_RST;
              cnt_next = CNT_RST;
              rst_n_next = 1'b0;
              exp_n_next = ~p_extended;
            end else begin
              cnt_next = cnt_reg + 15'h0001;
            end
          end
        end
        default: begin
          state_next = ST_RST;
          cnt_next = CNT_RST;
          rst_n_next = 1'b0;
        end
      endcase
    end
  end

  // Power-on starts with a full reset-active interval
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_RST;
      cnt_reg <= CNT_RST;
      rst_n_reg <= 1'b0;
      exp_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rst_n_reg <= rst_n_next;
      exp_n_reg <= exp_n_next;
    end
  end

  assign o_reset_n = rst_n_reg;
  assign o_expired_output_n = exp_n_reg;

endmodule // swt_watchdog

/* swt_watchdog_properties.sv */
`timescale 1ns/1ns
module swt_watchdog_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_kick_input,
  input wire logic i_kick_float,
  input wire logic i_power_low,
  input wire logic o_reset_n,
  input wire logic o_expired_output_n
);
  logic [15:0] lo_cnt;
  logic [15:0] hi_cnt;
  logic [2:0] age;
  logic k_d;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Saturating, so long spans never wrap
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lo_cnt <= 16'h0000;
      hi_cnt <= 16'h0000;
      age <= 3'h7;
      k_d <= 1'b0;
    end else begin
      lo_cnt <= o_reset_n ? 16'h0000 : lo_cnt + {15'h0000, ~&lo_cnt};
      hi_cnt <= !o_reset_n ? 16'h0000 : hi_cnt + {15'h0000, ~&hi_cnt};
      age <= (i_kick_input != k_d) ? 3'h0 : age + {2'h0, ~&age};
      k_d <= i_kick_input;
    end
  end
  a_power_holds_reset: assert property (i_power_low |=> !o_reset_n)
    else $error("reset not held");
  a_power_sets_expired: assert property
    (i_power_low |=> o_expired_output_n) else $error("expired low");
  a_expire_with_reset: assert property
    ($fell(o_expired_output_n) |-> $fell(o_reset_n)) else $error("lone expiry");
  a_expired_kick_rise: assert property
    ($rose(o_expired_output_n) |-> age < 3'h6 || $past(i_power_low))
    else $error("expired rose without kick");
  a_reset_active_len: assert property
    ($rose(o_reset_n) |-> lo_cnt >= 16'h0fa0 && !$past(i_power_low))
    else $error("reset too short");
  a_timeout_not_early: assert property
    ($fell(o_reset_n) |-> hi_cnt >= 16'h0fa0 || $past(i_power_low))
    else $error("timeout too early");
  a_float_no_timeout: assert property
    (i_kick_float && !i_power_low && o_reset_n |=> o_reset_n)
    else $error("timeout while floating");
  a_power_clear_restart: assert property
    ($fell(i_power_low) |=> !o_reset_n [*8]) else $error("no reset interval");
endmodule // swt_watchdog_checker

/* swt_host_model.sv */
`timescale 1ns/1ns
module swt_host_model (
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic [15:0] i_gap,
  output logic o_kick
);
  logic [15:0] cnt_reg;
  initial begin
    o_kick = 1'b0;
    cnt_reg = 16'h0000;
  end
  // Either edge serves, so a plain toggle per gap
  always @(posedge i_clk) begin
    if (!i_en || cnt_reg >= i_gap) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
    if (i_en && cnt_reg >= i_gap) begin
      o_kick <= ~o_kick;
    end
  end
endmodule // swt_host_model

/* tb_supervisor_watchdog_timer.sv */
`timescale 1ns/1ns
module tb_supervisor_watchdog_timer;
  import swt_pkg::*;
  logic i_clk, i_rst, kick, kick_float, ext_clk, power_low, en;
  logic reset_n, exp_n, sel;
  logic [15:0] gap;
  logic [1:0] div;
  logic [31:0] lfsr;
  int bad_count, checks, n;
  swt_watchdog #(.p_extended(1'b1), .p_osc_div(4)) swt_watchdog_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_kick_input(kick),
    .i_kick_float(kick_float), .i_timebase_select(sel),
    .i_select_float(1'b0), .i_timebase_input(ext_clk & ~sel),
    .i_timebase_float(1'b0), .i_power_low(power_low),
    .o_reset_n(reset_n), .o_expired_output_n(exp_n));
  swt_host_model swt_host_model_inst (.i_clk(i_clk), .i_en(en),
    .i_gap(gap), .o_kick(kick));
  function automatic int ext_cyc(input logic [CNT_W-1:0] clks);
    return int'(clks) * 4;
  endfunction
  task automatic chk(input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // External time base at a quarter of the clock rate
  always @(posedge i_clk) begin
    div <= div + 2'h1;
    ext_clk <= div[1];
  end
  initial begin
    #1_000_000;
    bad_count++;
    tally_and_finish;
  end
  initial begin
    {i_rst, kick_float, power_low, en, ext_clk} = 5'b10000;
    sel = 1'b0;
    {gap, div, lfsr, bad_count, checks} = {16'h0bb8, 2'h0, 32'hc571, 64'h0};
    cyc(4);
    i_rst <= 1'b0;
    cyc(ext_cyc(TK_RST_EXT) - 90);
    chk(reset_n, 1'b0);
    cyc(150);
    chk(reset_n, 1'b1);
    cyc(ext_cyc(TK_LONG_EXT) - 250);
    chk(reset_n, 1'b1);
    cyc(300);
    chk(reset_n, 1'b0);
    chk(exp_n, 1'b0);
    en <= 1'b1;
    cyc(3100);
    chk(exp_n, 1'b1);
    cyc(5300);
    chk(reset_n, 1'b1);
    for (int i = 0; i < 4; i++) begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      gap <= 16'h07d0 + {6'h00, lfsr[9:0]};
      cyc(3000);
      chk(reset_n, 1'b1);
    end
    @(kick);
    en <= 1'b0;
    n = 0;
    while (reset_n && n < 20000) begin
      cyc(1);
      n++;
    end
    chk(n > ext_cyc(TK_SHORT_EXT) - 8 && n < ext_cyc(TK_SHORT_EXT) + 8, 1);
    power_low <= 1'b1;
    cyc(2);
    chk(exp_n, 1'b1);
    cyc(ext_cyc(TK_RST_EXT) + 500);
    chk(reset_n, 1'b0);
    power_low <= 1'b0;
    cyc(ext_cyc(TK_RST_EXT) - 90);
    chk(reset_n, 1'b0);
    cyc(150);
    chk(reset_n, 1'b1);
    kick_float <= 1'b1;
    cyc(ext_cyc(TK_LONG_EXT) + 1000);
    chk(reset_n, 1'b1);
    // Internal oscillator, timebase low: short timeout in divider ticks
    kick_float <= 1'b0;
    sel <= 1'b1;
    en <= 1'b1;
    cyc(4000);
    chk(reset_n, 1'b1);
    @(kick);
    en <= 1'b0;
    n = 0;
    while (reset_n && n < 20000) begin
      cyc(1);
      n++;
    end
    chk(n > ext_cyc(TK_SHORT_INT) - 8 && n < ext_cyc(TK_SHORT_INT) + 8, 1);
    chk(exp_n, 1'b0);
    tally_and_finish;
  end
endmodule // tb_supervisor_watchdog_timer
bind swt_watchdog swt_watchdog_checker swt_watchdog_checker_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_kick_input(i_kick_input),
  .i_kick_float(i_kick_float), .i_power_low(i_power_low),
  .o_reset_n(o_reset_n), .o_expired_output_n(o_expired_output_n));
